/* inc/cgd_if.sv */
// three-wire serial configuration link between host and device
`timescale 1ns/1ps
interface cgd_if;
  logic ser_clk;
  logic ser_data;
  logic serial_latch_enable;

  modport host
  (
    output ser_clk,
    output ser_data,
    output serial_latch_enable
  );

  modport device
  (
    input  ser_clk,
    input  ser_data,
    input  serial_latch_enable
  );
endinterface : cgd_if

/* inc/cgd_pkg.sv */
// shared constants for the clock group divider and delay control block
package cgd_pkg;

  // frame layout: 32-bit word, MSB first, address in the low five bits
  localparam int FRAME_BITS = 32;
  localparam int ADDR_W     = 5;
  localparam int ADDR_LSB   = 0;
  localparam int NUM_GROUPS = 6;

  // register addresses
  localparam logic [4:0] ADDR_GRP_FIRST = 5'h00;
  localparam logic [4:0] ADDR_GRP_LAST  = 5'h05;
  localparam logic [4:0] ADDR_NOSYNC    = 5'h0B;
  localparam logic [4:0] ADDR_FBDIV     = 5'h1E;

  // group register field positions
  localparam int PD_BIT        = 31;
  localparam int SRC_BIT       = 30;
  localparam int ODD_ADLY_BIT  = 29;
  localparam int EVEN_ADLY_BIT = 28;
  localparam int DDLY_LSB      = 18;
  localparam int DDLY_W        = 10;
  localparam int RESET_BIT     = 17;
  localparam int PWDN_BIT      = 17;
  localparam int HS_BIT        = 16;
  localparam int DIV_LSB       = 5;
  localparam int DIV_W         = 11;
  localparam int NOSYNC_LSB    = 5;

  // groups that carry the special bits
  localparam int RESET_GRP = 0;
  localparam int PWDN_GRP  = 1;
  localparam int SRC_GRP_A = 3;
  localparam int SRC_GRP_B = 4;

  // delay and divide thresholds
  localparam logic [9:0]  DDLY_MIN = 10'h005;
  localparam logic [9:0]  DDLY_EXT = 10'h00D;
  localparam logic [10:0] DIV_EXT  = 11'h01A;
  localparam logic [10:0] DIV_ONE  = 11'h001;
  localparam logic [10:0] DIV_TWO  = 11'h002;
  localparam logic [10:0] DIV_FOUR = 11'h004;
  localparam logic [10:0] DIV_FIVE = 11'h005;

  // values after reset
  localparam logic [31:0] GRP_DEFAULT    = 32'h0014_0020;
  localparam logic [5:0]  NOSYNC_DEFAULT = 6'h00;

  // cycle counts
  localparam int VCO_DIV_DEFAULT  = 1;
  localparam int SER_HALF_DEFAULT = 2;

endpackage : cgd_pkg

/* src/cgd_device.sv */
// device end: serial receiver, group control registers and six output groups
`timescale 1ns/1ps
module cgd_device
  import cgd_pkg::*;
#(
  parameter int VCO_DIV = VCO_DIV_DEFAULT
)
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  cgd_if.device                      link,
  input  wire logic                  sync_req,
  output logic [2*NUM_GROUPS-1:0]    clk_out,
  output logic [NUM_GROUPS-1:0]      group_ext_mode,
  output logic [2*NUM_GROUPS-1:0]    analog_delay_en,
  output logic [NUM_GROUPS-1:0]      analog_delay_pd,
  output logic [NUM_GROUPS-1:0]      group_source_osc,
  output logic                       device_power_down,
  output logic                       soft_reset_bit,
  output logic                       auto_sync
);

  // link pins are taken as synchronous to mclk, so one flop gives edge detection
  logic        sclk_q_r;
  logic        le_q_r;
  logic [31:0] shift_r;
  logic        reset_pend_r;
  logic        reset_bit_r;
  logic        auto_sync_r;
  logic [5:0]  nosync_r;
  logic [31:0] grp_r [NUM_GROUPS];
  logic [7:0]  tick_cnt_r;
  logic        tick;

  wire       sclk_rise = link.ser_clk & ~sclk_q_r;
  wire       le_rise   = link.serial_latch_enable & ~le_q_r;
  wire       le_fall   = ~link.serial_latch_enable & le_q_r;
  wire [4:0] wr_addr   = shift_r[ADDR_LSB +: ADDR_W];
  wire       wr_grp    = le_rise & (wr_addr <= ADDR_GRP_LAST);
  wire       reset_wr  = wr_grp & (wr_addr == ADDR_GRP_FIRST) & shift_r[RESET_BIT];
  wire       other_wr  = le_rise & ~reset_wr;
  wire       do_reset  = le_fall & reset_pend_r;
  wire       sync_evt  = sync_req | auto_sync_r;
  wire       dev_pd    = grp_r[PWDN_GRP][PWDN_BIT];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sclk_q_r <= 1'b0;
      le_q_r   <= 1'b0;
      shift_r  <= 32'h0000_0000;
    end
    else
    begin
      sclk_q_r <= link.ser_clk;
      le_q_r   <= link.serial_latch_enable;
      if (sclk_rise)
      begin
        shift_r <= {shift_r[FRAME_BITS-2:0], link.ser_data};
      end
    end
  end

  // reset bit: pending until the latch falls, visible until any other write
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reset_pend_r <= 1'b0;
      reset_bit_r  <= 1'b0;
    end
    else
    begin
      if (reset_wr)
      begin
        reset_pend_r <= 1'b1;
        reset_bit_r  <= 1'b1;
      end
      else if (other_wr)
      begin
        reset_bit_r <= 1'b0;
      end
      if (do_reset)
      begin
        reset_pend_r <= 1'b0;
      end
    end
  end

  // writing the feedback divider restarts groups that need phase realignment
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      auto_sync_r <= 1'b0;
      nosync_r    <= NOSYNC_DEFAULT;
    end
    else
    begin
      auto_sync_r <= le_rise & (wr_addr == ADDR_FBDIV);
      if (do_reset)
      begin
        nosync_r <= NOSYNC_DEFAULT;
      end
      else if (le_rise & (wr_addr == ADDR_NOSYNC))
      begin
        nosync_r <= shift_r[NOSYNC_LSB +: NUM_GROUPS];
      end
    end
  end

  // distribution half-period tick: one per VCO_DIV master cycles
  always_ff @(posedge mclk)
  begin
    if (rst || tick)
    begin
      tick_cnt_r <= 8'h00;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  assign tick = (tick_cnt_r == 8'(VCO_DIV - 1));

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++)
    begin : gen_grp
      logic grp_clk;

      // a reset write stores nothing; defaults land at the latch fall
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          grp_r[g] <= GRP_DEFAULT;
        end
        else if (do_reset)
        begin
          grp_r[g] <= GRP_DEFAULT;
        end
        else if (wr_grp && !reset_wr && wr_addr == 5'(g))
        begin
          grp_r[g] <= shift_r;
        end
      end

      cgd_group #(
        .HAS_SRC (g == SRC_GRP_A || g == SRC_GRP_B)
      ) u_grp (
        .mclk         (mclk),
        .rst          (rst),
        .tick         (tick),
        .sync_evt     (sync_evt),
        .ctrl         (grp_r[g]),
        .no_sync      (nosync_r[g]),
        .dev_pd       (dev_pd),
        .grp_clk      (grp_clk),
        .ext_mode     (group_ext_mode[g]),
        .even_adly_en (analog_delay_en[2*g]),
        .odd_adly_en  (analog_delay_en[2*g+1]),
        .adly_pd      (analog_delay_pd[g]),
        .src_osc      (group_source_osc[g])
      );

      // both outputs of a pair carry the same divided clock
      assign clk_out[2*g]   = grp_clk;
      assign clk_out[2*g+1] = grp_clk;
    end
  endgenerate

  // the reset register stores no reset bit, so bit 17 of group 0 stays clear
  wire unused_rst_grp = grp_r[RESET_GRP][RESET_BIT];

  assign device_power_down = dev_pd;
  assign soft_reset_bit    = reset_bit_r;
  assign auto_sync         = auto_sync_r;

endmodule : cgd_device

/* src/cgd_group.sv */
// one output group: applied delay, half-step shift and 50% duty divider
`timescale 1ns/1ps
module cgd_group
  import cgd_pkg::*;
#(
  parameter bit HAS_SRC = 1'b0
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        sync_evt,
  input  wire logic [31:0] ctrl,
  input  wire logic        no_sync,
  input  wire logic        dev_pd,
  output logic             grp_clk,
  output logic             ext_mode,
  output logic             even_adly_en,
  output logic             odd_adly_en,
  output logic             adly_pd,
  output logic             src_osc
);

  // time base is half a distribution period per tick, so odd divides stay at 50%
  logic [11:0] cnt_r;
  logic        dly_act_r;
  logic        out_r;
  logic        hs_q_r;

  wire         pd       = ctrl[PD_BIT] | dev_pd;
  wire  [9:0]  ddly     = ctrl[DDLY_LSB +: DDLY_W];
  wire  [10:0] div_raw  = ctrl[DIV_LSB +: DIV_W];
  wire         hs       = ctrl[HS_BIT];
  // code 0 is reserved; it divides by one rather than stall the group
  wire  [10:0] div_eff  = (div_raw == 11'h000) ? DIV_ONE : div_raw;
  wire  [9:0]  ddly_eff = (ddly < DDLY_MIN) ? DDLY_MIN : ddly;
  wire  [11:0] dly_half = {1'b0, ddly_eff, 1'b0} - {11'h000, hs};
  wire         apply    = sync_evt & ~no_sync;
  wire         hs_adv   = hs & ~hs_q_r;
  wire         hs_hold  = ~hs & hs_q_r;
  wire  [11:0] step     = hs_adv ? 12'h002 : (hs_hold ? 12'h000 : 12'h001);
  wire         expire   = cnt_r <= step;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r      <= 12'h001;
      dly_act_r  <= 1'b0;
      out_r      <= 1'b0;
      hs_q_r     <= 1'b0;
    end
    else if (pd)
    begin
      out_r <= 1'b0;
    end
    else if (apply)
    begin
      cnt_r      <= dly_half;
      dly_act_r  <= 1'b1;
      out_r      <= 1'b0;
      hs_q_r     <= hs;
    end
    else if (tick)
    begin
      hs_q_r <= hs;
      if (expire)
      begin
        cnt_r     <= {1'b0, div_eff};
        dly_act_r <= 1'b0;
        out_r     <= dly_act_r ? 1'b1 : ~out_r;
      end
      else
      begin
        cnt_r <= cnt_r - step;
      end
    end
  end

  // status decodes are registered so every data output comes from a flop
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ext_mode     <= 1'b0;
      even_adly_en <= 1'b0;
      odd_adly_en  <= 1'b0;
      adly_pd      <= 1'b1;
      src_osc      <= 1'b0;
    end
    else
    begin
      ext_mode     <= ~pd & ((ddly >= DDLY_EXT) | (div_raw >= DIV_EXT));
      even_adly_en <= ~pd & ctrl[EVEN_ADLY_BIT];
      odd_adly_en  <= ~pd & ctrl[ODD_ADLY_BIT];
      adly_pd      <= pd | ~(ctrl[EVEN_ADLY_BIT] | ctrl[ODD_ADLY_BIT]);
      src_osc      <= HAS_SRC & ctrl[SRC_BIT];
    end
  end

  assign grp_clk = out_r;

endmodule : cgd_group

/* src/cgd_host.sv */
// host end: serialises register writes onto the three-wire link
`timescale 1ns/1ps
module cgd_host
  import cgd_pkg::*;
#(
  parameter int SER_HALF = SER_HALF_DEFAULT
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  cgd_if.host              link,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [4:0]  wr_addr,
  input  wire logic [26:0] wr_data
);

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0001,
    ST_LOW   = 4'b0010,
    ST_HIGH  = 4'b0100,
    ST_LATCH = 4'b1000
  } cgd_state_type;

  cgd_state_type state_r;
  logic [31:0]   word_r;
  logic [4:0]    bit_r;
  logic [7:0]    hcnt_r;
  logic          sclk_r;
  logic          data_r;
  logic          le_r;
  logic [5:0]    resync_r;

  wire         htick   = (hcnt_r == 8'(SER_HALF - 1));
  wire         take    = wr_valid & (state_r == ST_IDLE);
  wire [31:0]  raw     = {wr_data, wr_addr};
  wire [10:0]  w_div   = raw[DIV_LSB +: DIV_W];
  wire         is_grp  = wr_addr <= ADDR_GRP_LAST;
  wire         need_rs = (w_div == DIV_TWO) | (w_div == DIV_FOUR) | (w_div == DIV_FIVE);
  logic [31:0] word;

  // guard the two host obligations on the outgoing word
  always_comb
  begin
    word = raw;
    if (is_grp && w_div == DIV_ONE)
    begin
      word[HS_BIT] = 1'b0;
    end
    if (wr_addr == ADDR_NOSYNC)
    begin
      word[NOSYNC_LSB +: NUM_GROUPS] = raw[NOSYNC_LSB +: NUM_GROUPS] & ~resync_r;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      resync_r <= 6'h00;
    end
    else if (take && is_grp)
    begin
      resync_r[wr_addr[2:0]] <= need_rs;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || take || htick)
    begin
      hcnt_r <= 8'h00;
    end
    else if (state_r != ST_IDLE)
    begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end

  // reset and power-down bits pass as given; the user rewrites them to clear
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      word_r  <= 32'h0000_0000;
      bit_r   <= 5'h00;
      sclk_r  <= 1'b0;
      data_r  <= 1'b0;
      le_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (take)
          begin
            word_r  <= word;
            data_r  <= word[FRAME_BITS-1];
            bit_r   <= 5'h1F;
            state_r <= ST_LOW;
          end
        end
        ST_LOW:
        begin
          if (htick)
          begin
            sclk_r  <= 1'b1;
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH:
        begin
          if (htick)
          begin
            sclk_r <= 1'b0;
            if (bit_r == 5'h00)
            begin
              le_r    <= 1'b1;
              state_r <= ST_LATCH;
            end
            else
            begin
              bit_r   <= bit_r - 5'h01;
              word_r  <= {word_r[FRAME_BITS-2:0], 1'b0};
              data_r  <= word_r[FRAME_BITS-2];
              state_r <= ST_LOW;
            end
          end
        end
        ST_LATCH:
        begin
          if (htick)
          begin
            le_r    <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign wr_ready                 = (state_r == ST_IDLE);
  assign link.ser_clk             = sclk_r;
  assign link.ser_data            = data_r;
  assign link.serial_latch_enable = le_r;

endmodule : cgd_host

/* verification/cgd_checker.sv */
// concurrent checks on the serial link and the device group outputs
`timescale 1ns/1ps
module cgd_checker
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ser_clk,
  input wire logic        ser_data,
  input wire logic        serial_latch_enable,
  input wire logic [11:0] clk_out,
  input wire logic [11:0] analog_delay_en,
  input wire logic [5:0]  analog_delay_pd,
  input wire logic [5:0]  group_source_osc,
  input wire logic        device_power_down,
  input wire logic        soft_reset_bit,
  input wire logic        auto_sync
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic [5:0] sel_any;

  always_comb
    for (int g = 0; g < 6; g++)
      sel_any[g] = |analog_delay_en[2*g +: 2];

  property p_le_clk_low;
    serial_latch_enable |-> !ser_clk;
  endproperty
  a_le_clk_low: assert property (p_le_clk_low)
    else $error("latch enable high while serial clock high");

  property p_data_hold;
    ser_clk && $past(ser_clk) |-> $stable(ser_data);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("serial data moved during clock high phase");

  property p_src_groups;
    (group_source_osc & 6'h27) == 6'h00;
  endproperty
  a_src_groups: assert property (p_src_groups)
    else $error("oscillator source on a group without the select");

  property p_adly_pd;
    (~analog_delay_pd & ~sel_any) == 6'h00;
  endproperty
  a_adly_pd: assert property (p_adly_pd)
    else $error("analog delay powered with no output selecting it");

  property p_pair;
    (clk_out & 12'h555) == ((clk_out >> 1) & 12'h555);
  endproperty
  a_pair: assert property (p_pair)
    else $error("even and odd outputs of a group differ");

  property p_pd_low;
    device_power_down [*3] |-> clk_out == 12'h000;
  endproperty
  a_pd_low: assert property (p_pd_low)
    else $error("output clock running in device power-down");

  property p_sync_pulse;
    auto_sync |=> !auto_sync;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("automatic sync longer than one cycle");

  property p_srst_set;
    $rose(soft_reset_bit) |-> $past(serial_latch_enable) || $past(serial_latch_enable, 2);
  endproperty
  a_srst_set: assert property (p_srst_set)
    else $error("reset bit set without a latch");

  property p_srst_clear;
    $fell(soft_reset_bit) |-> $past(serial_latch_enable) || $past(serial_latch_enable, 2);
  endproperty
  a_srst_clear: assert property (p_srst_clear)
    else $error("reset bit cleared without a latch");

  c_sync: cover property (auto_sync);
  c_srst: cover property ($rose(soft_reset_bit));
  c_pd: cover property (device_power_down);
  c_clk: cover property ($rose(clk_out[0]));
endmodule : cgd_checker

/* verification/clock_group_divider_delay_ctrl_tb.sv */
// self-checking bench: host end drives the device end over the serial link
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module clock_group_divider_delay_ctrl_tb
  import cgd_pkg::*;
;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        wr_valid = 1'b0;
  logic        wr_ready;
  logic [4:0]  wr_addr  = 5'h00;
  logic [26:0] wr_data  = 27'h0;
  logic        sync_req = 1'b0;
  logic [11:0] clk_out;
  logic [11:0] adly_en;
  logic [5:0]  ext;
  logic [5:0]  adly_pd;
  logic [5:0]  src;
  logic        dev_pd;
  logic        srst;
  logic        auto_sync;
  int          errors   = 0;
  int          n_tests  = 0;
  int          n_sync   = 0;

  cgd_if link();

  always #20 mclk = ~mclk;

  always @(posedge mclk)
    if (auto_sync === 1'b1)
      n_sync++;

  cgd_host i_cgd_host
  (
    .mclk(mclk), .rst(rst), .link(link.host), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
  );

  cgd_device i_cgd_device
  (
    .mclk(mclk), .rst(rst), .link(link.device), .sync_req(sync_req),
    .clk_out(clk_out), .group_ext_mode(ext), .analog_delay_en(adly_en),
    .analog_delay_pd(adly_pd), .group_source_osc(src), .device_power_down(dev_pd),
    .soft_reset_bit(srst), .auto_sync(auto_sync)
  );

  cgd_checker i_cgd_checker
  (
    .mclk(mclk), .rst(rst), .ser_clk(link.ser_clk), .ser_data(link.ser_data),
    .serial_latch_enable(link.serial_latch_enable), .clk_out(clk_out),
    .analog_delay_en(adly_en), .analog_delay_pd(adly_pd), .group_source_osc(src),
    .device_power_down(dev_pd), .soft_reset_bit(srst), .auto_sync(auto_sync)
  );

  task automatic close_out(input bit timed_out);
    if (timed_out)
      errors++;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // waits on the falling edge so the combinational ready has settled
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge mclk);
    while (wr_ready !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400)
      close_out(1'b1);
  endtask : wait_ready

  task automatic wr(input logic [4:0] a, input logic [26:0] d);
    wait_ready();
    @(posedge mclk);
    wr_valid <= 1'b1;
    wr_addr  <= a;
    wr_data  <= d;
    @(posedge mclk);
    wr_valid <= 1'b0;
    wait_ready();
    repeat (4) @(negedge mclk);
  endtask : wr

  task automatic pulse_sync();
    @(posedge mclk);
    sync_req <= 1'b1;
    @(posedge mclk);
    sync_req <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask : pulse_sync

  task automatic chk_grp(input int g, input logic s, input logic [1:0] a,
                         input logic [9:0] d, input logic h, input logic [10:0] v);
    wr(5'(g), {1'b0, s, a, d, 1'b0, h, v});
    pulse_sync();
    `CHK(ext[g], (d >= DDLY_EXT) || (v >= DIV_EXT))
    `CHK(adly_en[2*g +: 2], a)
    `CHK(adly_pd[g], a == 2'h0)
    `CHK(src[g], s && (g == SRC_GRP_A || g == SRC_GRP_B))
  endtask : chk_grp

  task automatic run_len(input logic lvl, input int v);
    int n;
    n = 0;
    while (clk_out[0] === lvl && n < 3000)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK(n, v)
  endtask : run_len

  // highs of output 0 over a fixed window: a running divide-by-3 gives exactly half
  task automatic count_hi(output int h);
    h = 0;
    repeat (12)
    begin
      @(negedge mclk);
      if (clk_out[0] === 1'b1)
        h++;
    end
  endtask : count_hi

  // a rise only counts after six lows, so a stale toggle before sync is skipped
  task automatic meas(input logic [9:0] d, input logic hs, input logic [10:0] v,
                      output int lat);
    int lows;
    wr(5'h00, {4'h0, d, 1'b0, hs, v});
    @(posedge mclk);
    sync_req <= 1'b1;
    @(posedge mclk);
    sync_req <= 1'b0;
    lat  = 0;
    lows = 0;
    do
    begin
      @(negedge mclk);
      lat++;
      if (clk_out[0] === 1'b1 && lows >= 6)
        break;
      lows = (clk_out[0] === 1'b0) ? lows + 1 : 0;
    end while (lat < 3000);
    if (lat >= 3000)
      close_out(1'b1);
    run_len(1'b1, int'(v));
    run_len(1'b0, int'(v));
  endtask : meas

  initial
  begin
    int r;
    int la;
    int lb;
    int lc;
    int ld;
    int hc;
    logic [20:0] et [6];
    r  = $urandom(32'hEE9C);
    et = '{{10'h00C, 11'h019}, {10'h00D, 11'h001}, {10'h005, 11'h01A},
           {10'h000, 11'h019}, {10'h20A, 11'h415}, {10'h006, 11'h002}};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({ext, src, adly_pd, dev_pd, srst}, 20'h000FC)
    `CHK({clk_out, adly_en}, 24'h000000)
    for (int g = 0; g < 6; g++)
      for (int c = 0; c < 4; c++)
        chk_grp(g, 1'b1, 2'(c), 10'h005, 1'b0, 11'h001);
    foreach (et[i])
      chk_grp($urandom_range(5), 1'b0, 2'h0, et[i][20:11], 1'b0, et[i][10:0]);
    repeat (12)
    begin
      r = $urandom_range(1045, 1);
      chk_grp($urandom_range(5), 1'($urandom_range(1)), 2'($urandom_range(3)),
              10'($urandom_range(522)), (r != 1) && $urandom_range(1), 11'(r));
    end
    wr(5'h02, {4'hB, 10'h00D, 2'h0, 11'h01A});
    pulse_sync();
    `CHK({ext[2], adly_pd[2], clk_out[5:4]}, 4'h4)
    wr(5'h01, 27'h0001001);
    pulse_sync();
    `CHK({dev_pd, clk_out}, 13'h1000)
    wr(5'h01, 27'h0000001);
    `CHK(dev_pd, 1'b0)
    chk_grp(2, 1'b0, 2'h3, 10'h005, 1'b0, 11'h001);
    wr(5'h00, 27'h1801001);
    `CHK({srst, adly_pd, adly_en}, 19'h7F000)
    chk_grp(3, 1'b0, 2'h1, 10'h005, 1'b0, 11'h001);
    `CHK(srst, 1'b0)
    r = n_sync;
    wr(5'h1E, 27'($urandom()));
    `CHK(n_sync - r, 1)
    meas(10'h000, 1'b0, 11'h003, la);
    meas(10'h005, 1'b0, 11'h004, lb);
    `CHK(lb, la)
    meas(10'h009, 1'b0, 11'h004, lc);
    `CHK(lc, lb + 8)
    meas(10'h009, 1'b1, 11'h004, ld);
    `CHK(ld, lc - 1)
    // no-sync set on a divide-by-3 group: the sync must leave it running
    wr(5'h00, {4'h0, 10'h040, 2'h0, 11'h003});
    wr(5'h0B, 27'h0000001);
    pulse_sync();
    count_hi(hc);
    `CHK(hc, 6)
    // divide-by-4 group: the host strips its no-sync bit, so the sync restarts it
    wr(5'h00, {4'h0, 10'h040, 2'h0, 11'h004});
    wr(5'h0B, 27'h0000001);
    pulse_sync();
    count_hi(hc);
    `CHK(hc, 0)
    close_out(1'b0);
  end
endmodule : clock_group_divider_delay_ctrl_tb
